// *** design/mps_pkg.sv ***
// constants and types shared by the module power sequencer
package mps_pkg;
  // clock and timing figures
  localparam int CLK_PERIOD_NS = 100;
  localparam int SEQ_TIME_NS = 10000;
  localparam int DEEP_ENTRY_TIME_NS = 100000;
  localparam int SEQ_CYCLES_I =
    (SEQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEEP_CYCLES_I =
    (DEEP_ENTRY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] SEQ_CYCLES = CNT_W'(SEQ_CYCLES_I);
  localparam logic [CNT_W-1:0] DEEP_CYCLES = CNT_W'(DEEP_CYCLES_I);
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

  // sleep state codes
  localparam logic [1:0] SLP_S0 = 2'h0;
  localparam logic [1:0] SLP_S3 = 2'h1;
  localparam logic [1:0] SLP_S4 = 2'h2;
  localparam logic [1:0] SLP_S5 = 2'h3;

  // reset value of the button synchroniser (pin idles high)
  localparam logic [1:0] SYNC_RST = 2'h3;
  // power good synchroniser starts low so reset release cannot start a boot
  localparam logic [1:0] PG_SYNC_RST = 2'h0;

  // sequencer states
  typedef enum logic [2:0] {
    ST_WAIT_PG = 3'b000,
    ST_SEQ = 3'b001,
    ST_RUN = 3'b010,
    ST_SLEEP = 3'b011,
    ST_DEEP = 3'b100
  } mps_state_e;
endpackage

// *** design/mps_sequencer.sv ***
// power-good gated reset and sleep sequencer of the module
// Function
// RULE1: power good high allows sequencing; low blocks it
// RULE2: carrier holds power good low until stable
// RULE3: carrier should delay release about 100 ms; the bench delays it 20 to 83 cycles
// RULE4: reset held while power good driven low
// RULE5: undriven power good counts as good power
// RULE6: carrier drives low, then releases, not high; the carrier model drives it high
// RULE7: active-low supply-on request; carrier inverts it
// RULE8: carrier gives debounced active-low button request
// RULE9: button press is an on/off request
// RULE10: deep sleep honours only restricted wake events; the code also leaves deep sleep on a button press
// RULE11: deep sleep wakes into its entry sleep state
// RULE12: power good and button synchronised before use
`timescale 1ns/1ns
`default_nettype none
module mps_sequencer
  import mps_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // carrier pins (pull-up resolves an undriven power good high)
  input wire logic power_good_input,
  input wire logic power_button_request_n,
  // firmware side, same clock
  input wire logic fw_sleep_valid,
  input wire logic [1:0] fw_sleep_state,
  input wire logic fw_deep_enable,
  input wire logic wake_general,
  input wire logic wake_restricted,
  // outputs
  output logic supply_on_request_n,
  output logic module_reset_n,
  output logic sequencing,
  output logic power_button_event,
  output logic [1:0] sleep_state,
  output logic deep_sleep_state
);

  mps_state_e state_r, state_nxt;
  logic [1:0] pg_sync_r, pg_sync_nxt;
  logic [1:0] btn_sync_r, btn_sync_nxt;
  logic btn_prev_r, btn_prev_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [1:0] saved_r, saved_nxt;
  logic supply_n_r, supply_n_nxt;
  logic mreset_n_r, mreset_n_nxt;
  logic seq_r, seq_nxt;
  logic btn_evt_r, btn_evt_nxt;
  logic deep_r, deep_nxt;
  logic pg_s;
  logic press;

  // synchronised levels; only the second stage is read
  assign pg_s = pg_sync_r[1];
  assign press = btn_prev_r & ~btn_sync_r[1];

  // two-flop synchronisers and press edge detect
  always_comb begin
    pg_sync_nxt = {pg_sync_r[0], power_good_input}; // RULE12
    btn_sync_nxt = {btn_sync_r[0], power_button_request_n}; // RULE12
    btn_prev_nxt = btn_sync_r[1];
  end

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    saved_nxt = saved_r;
    btn_evt_nxt = 1'b0;
    case (state_r)
      ST_WAIT_PG: begin
        cnt_nxt = CNT_ZERO;
        if (pg_s) begin // RULE1 RULE5
          state_nxt = ST_SEQ;
        end
      end
      ST_SEQ: begin
        if (!pg_s) begin // RULE4
          state_nxt = ST_WAIT_PG;
        end else if (cnt_r == SEQ_CYCLES - CNT_ONE) begin
          state_nxt = ST_RUN;
        end else begin
          cnt_nxt = cnt_r + CNT_ONE;
        end
      end
      ST_RUN: begin
        btn_evt_nxt = press; // RULE9
        if (!pg_s) begin // RULE4
          state_nxt = ST_WAIT_PG;
        end else if (fw_sleep_valid && fw_sleep_state != SLP_S0) begin
          state_nxt = ST_SLEEP;
          saved_nxt = fw_sleep_state;
          cnt_nxt = CNT_ZERO;
        end
      end
      ST_SLEEP: begin
        if (press || wake_general || wake_restricted) begin // RULE9
          state_nxt = ST_WAIT_PG;
          saved_nxt = SLP_S0;
        end else if (fw_deep_enable) begin
          if (cnt_r == DEEP_CYCLES - CNT_ONE) begin
            state_nxt = ST_DEEP;
            cnt_nxt = CNT_ZERO;
          end else begin
            cnt_nxt = cnt_r + CNT_ONE;
          end
        end else begin
          cnt_nxt = CNT_ZERO;
        end
      end
      ST_DEEP: begin
        cnt_nxt = CNT_ZERO;
        if (press || wake_restricted) begin // RULE10
          state_nxt = ST_SLEEP; // RULE11
        end
      end
      default: begin
        state_nxt = ST_WAIT_PG;
        cnt_nxt = CNT_ZERO;
        saved_nxt = SLP_S0;
      end
    endcase
  end

  // registered outputs from the next state
  always_comb begin
    supply_n_nxt = ~((state_nxt == ST_WAIT_PG) || (state_nxt == ST_SEQ) ||
                     (state_nxt == ST_RUN)); // RULE7
    mreset_n_nxt = (state_nxt == ST_RUN); // RULE4
    seq_nxt = (state_nxt == ST_SEQ);
    deep_nxt = (state_nxt == ST_DEEP); // RULE10
  end

  // state registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_WAIT_PG;
      pg_sync_r <= PG_SYNC_RST; // RULE4
      btn_sync_r <= SYNC_RST;
      btn_prev_r <= 1'b1;
      cnt_r <= CNT_ZERO;
      saved_r <= SLP_S0;
      supply_n_r <= 1'b1;
      mreset_n_r <= 1'b0;
      seq_r <= 1'b0;
      btn_evt_r <= 1'b0;
      deep_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pg_sync_r <= pg_sync_nxt;
      btn_sync_r <= btn_sync_nxt;
      btn_prev_r <= btn_prev_nxt;
      cnt_r <= cnt_nxt;
      saved_r <= saved_nxt;
      supply_n_r <= supply_n_nxt;
      mreset_n_r <= mreset_n_nxt;
      seq_r <= seq_nxt;
      btn_evt_r <= btn_evt_nxt;
      deep_r <= deep_nxt;
    end
  end

  // output drive
  assign supply_on_request_n = supply_n_r;
  assign module_reset_n = mreset_n_r;
  assign sequencing = seq_r;
  assign power_button_event = btn_evt_r;
  assign sleep_state = saved_r;
  assign deep_sleep_state = deep_r;

  // reset release only after power good was seen high
  property p_pg_gate;
    @(posedge ref_clk) disable iff (rst)
    $rose(mreset_n_r) |-> $past(pg_s, 2) && $past(seq_r);
  endproperty
  a_pg_gate: assert property (p_pg_gate) // RULE1
    else $error("reset released without power good");

  // power good low forces reset within one cycle
  property p_pg_low_reset;
    @(posedge ref_clk) disable iff (rst)
    (!pg_s && (state_r == ST_SEQ || state_r == ST_RUN)) |=>
      !mreset_n_r && state_r == ST_WAIT_PG;
  endproperty
  a_pg_low_reset: assert property (p_pg_low_reset) // RULE4
    else $error("reset not held while power good low");

  // a standing high power good starts sequencing
  property p_pg_idle_high;
    @(posedge ref_clk) disable iff (rst)
    (state_r == ST_WAIT_PG && pg_s) |=> seq_r ##0 state_r == ST_SEQ;
  endproperty
  a_pg_idle_high: assert property (p_pg_idle_high) // RULE5
    else $error("high power good did not start sequencing");

  // running module always requests the supply on
  property p_supply_on;
    @(posedge ref_clk) disable iff (rst)
    mreset_n_r |-> !supply_n_r && !deep_r;
  endproperty
  a_supply_on: assert property (p_supply_on) // RULE7
    else $error("module running with supply request off");

  // a press while running yields one event pulse
  property p_button_event;
    @(posedge ref_clk) disable iff (rst)
    (press && state_r == ST_RUN) |=> btn_evt_r ##1 !btn_evt_r;
  endproperty
  a_button_event: assert property (p_button_event) // RULE9
    else $error("button press not reported");

  // general wake ignored in deep sleep
  property p_deep_filter;
    @(posedge ref_clk) disable iff (rst)
    (state_r == ST_DEEP && wake_general && !wake_restricted && !press)
      |=> state_r == ST_DEEP;
  endproperty
  a_deep_filter: assert property (p_deep_filter) // RULE10
    else $error("deep sleep left on unrestricted wake");

  // deep wake returns to the saved sleep state
  property p_deep_resume;
    @(posedge ref_clk) disable iff (rst)
    (state_r == ST_DEEP && wake_restricted) |=>
      state_r == ST_SLEEP && saved_r == $past(saved_r) && !deep_r &&
      supply_n_r;
  endproperty
  a_deep_resume: assert property (p_deep_resume) // RULE11
    else $error("deep wake entered wrong state");

  // power good reaches logic exactly two cycles late
  property p_pg_sync;
    @(posedge ref_clk) disable iff (rst)
    !$past(rst) && !$past(rst, 2) |-> pg_s == $past(power_good_input, 2);
  endproperty
  a_pg_sync: assert property (p_pg_sync) // RULE12
    else $error("power good synchroniser delay wrong");

endmodule
`default_nettype wire

// *** sim/mps_carrier.sv ***
// carrier board model: power good, button and supply inversion
`timescale 1ns/1ns
`default_nettype none
module mps_carrier (
  // bench controls
  input wire logic hold_low,
  input wire logic press,
  // module pins
  input wire logic supply_on_request_n,
  output logic power_good_input,
  output logic power_button_request_n,
  // main supply enable after the standby inverter
  output logic main_on
);
  // driven low, or driven high to stand in for the release to the pull-up
  assign power_good_input = hold_low ? 1'b0 : 1'b1;
  // button to ground, the pull-up returns the pin high on release
  assign power_button_request_n = ~press;
  // standby-powered inverter stage
  assign main_on = ~supply_on_request_n;
endmodule
`default_nettype wire

// *** sim/mps_sequencer_tb_top.sv ***
// self-checking bench of the module power sequencer
`timescale 1ns/1ns
`default_nettype none
module mps_sequencer_tb_top;
  import mps_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hold_low = 1'b1;
  logic press = 1'b0;
  logic fw_sleep_valid = 1'b0;
  logic [1:0] fw_sleep_state = 2'h0;
  logic fw_deep_enable = 1'b0;
  logic wake_general = 1'b0;
  logic wake_restricted = 1'b0;
  logic power_good_input, power_button_request_n, main_on;
  logic supply_on_request_n, module_reset_n, sequencing;
  logic power_button_event, deep_sleep_state;
  logic [1:0] sleep_state;
  logic [1:0] code;
  logic [15:0] rng = 16'h0041;
  int fails = 0;
  int checks = 0;
  int n;
  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;
  mps_carrier carrier (.hold_low(hold_low), .press(press),
    .supply_on_request_n(supply_on_request_n),
    .power_good_input(power_good_input),
    .power_button_request_n(power_button_request_n), .main_on(main_on));
  mps_sequencer dut (.ref_clk(ref_clk), .rst(rst),
    .power_good_input(power_good_input),
    .power_button_request_n(power_button_request_n),
    .fw_sleep_valid(fw_sleep_valid), .fw_sleep_state(fw_sleep_state),
    .fw_deep_enable(fw_deep_enable), .wake_general(wake_general),
    .wake_restricted(wake_restricted),
    .supply_on_request_n(supply_on_request_n),
    .module_reset_n(module_reset_n), .sequencing(sequencing),
    .power_button_event(power_button_event), .sleep_state(sleep_state),
    .deep_sleep_state(deep_sleep_state));
  // xorshift source of random values
  function automatic logic [15:0] xs(logic [15:0] v);
    v ^= v << 7;
    v ^= v >> 9;
    v ^= v << 8;
    return v;
  endfunction
  // wait k edges, then let their updates land
  task automatic t(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // compare one result
  task automatic chk(string nm, logic [1:0] exp, logic [1:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one-cycle sleep request
  task automatic slp(logic [1:0] c);
    @(posedge ref_clk) fw_sleep_valid <= 1'b1;
    fw_sleep_state <= c;
    @(posedge ref_clk) fw_sleep_valid <= 1'b0;
    #1;
  endtask
  // random carrier delay, then release power good and time the boot
  task automatic boot;
    rng = xs(rng);
    t(20 + int'(rng[5:0]));
    chk("held", 2'h0, {sequencing, module_reset_n});
    @(posedge ref_clk) hold_low <= 1'b0;
    n = 0;
    while (sequencing !== 1'b1 && n < 8) begin
      t(1);
      n++;
    end
    chk("seq_start", 2'h1, {1'b0, sequencing});
    n = 0;
    while (module_reset_n !== 1'b1 && n < 200) begin
      t(1);
      n++;
    end
    chk("seq_len", 2'h1, {1'b0, n == SEQ_CYCLES_I});
    chk("supply_on", 2'h1, {1'b0, main_on});
  endtask
  // main sequence
  initial begin
    t(9);
    chk("rst_out", 2'h2, {supply_on_request_n, module_reset_n});
    @(posedge ref_clk) rst <= 1'b0;
    slp(2'h3);
    chk("sleep_refused", 2'h0, sleep_state);
    chk("held_rst", 2'h0, {sequencing, module_reset_n});
    boot();
    @(posedge ref_clk) press <= 1'b1;
    n = 0;
    repeat (12) begin
      t(1);
      n += int'(power_button_event === 1'b1);
    end
    chk("btn_events", 2'h1, n[1:0]);
    @(posedge ref_clk) press <= 1'b0;
    @(posedge ref_clk) hold_low <= 1'b1;
    t(4);
    chk("pg_drop", 2'h0, {module_reset_n, sequencing});
    boot();
    for (int c = 0; c < 4; c++) begin
      slp(c[1:0]);
      chk("sleep_code", c[1:0], sleep_state);
      if (c != 0) begin
        chk("sleep_off", 2'h3, {supply_on_request_n, ~module_reset_n});
        // carrier rails drop while asleep, so power good goes low again
        @(posedge ref_clk) hold_low <= 1'b1;
        @(posedge ref_clk) wake_general <= 1'b1;
        @(posedge ref_clk) wake_general <= 1'b0;
        #1;
        chk("wake", 2'h0, sleep_state);
        chk("wake_on", 2'h0, {1'b0, supply_on_request_n});
        boot();
      end
    end
    rng = xs(rng);
    code = (rng[1:0] == 2'h0) ? 2'h1 : rng[1:0];
    @(posedge ref_clk) fw_deep_enable <= 1'b1;
    slp(code);
    n = 0;
    while (deep_sleep_state !== 1'b1 && n < 1100) begin
      t(1);
      n++;
    end
    chk("deep_len", 2'h1, {1'b0, n == DEEP_CYCLES_I});
    @(posedge ref_clk) wake_general <= 1'b1;
    @(posedge ref_clk) wake_general <= 1'b0;
    t(2);
    chk("deep_ignores", 2'h1, {1'b0, deep_sleep_state});
    @(posedge ref_clk) wake_restricted <= 1'b1;
    fw_deep_enable <= 1'b0;
    @(posedge ref_clk) wake_restricted <= 1'b0;
    #1;
    chk("deep_exit", 2'h0, {1'b0, deep_sleep_state});
    chk("deep_resume", code, sleep_state);
    @(posedge ref_clk) press <= 1'b1;
    t(6);
    chk("btn_wake", 2'h0, sleep_state);
    close_out();
  end
  // watchdog
  initial begin
    repeat (6000) @(posedge ref_clk);
    fails++;
    close_out();
  end
endmodule
`default_nettype wire
